//--- ctg_pkg.sv
// constants and carrier types for the codec control registers and tone generator
// Overview of operation
// - transmit override set: last written transmit byte goes out each frame, encoder ignored.
// - all PCM samples shift most significant bit first, both directions.
// - voice enable gates PCM; clear means no decode, transmit slot floats; resets clear.
// - slot select picks first or second B channel slot; default first.
// - supply select chooses supply setting; resets to the 3.3V setting.
// - receive data register holds host byte or received byte per receive override.
// - receive override set decodes register byte each frame; else register returns received byte.
// - transmit data register is write only; host gets no readback.
// - path register bits 7:6 choose one of three microphones or transmit mute.
// - sidetone enable bit drives sidetone, forced off while transmit path disabled.
// - two output enables choose earpiece, extra output or mute; never both set.
// - tone routing bit sends tone generator to extra or earpiece amplifier.
// - speech routing bit sends decoded speech to extra or earpiece amplifier.
// - gain register upper nibble sets transmit gain 0 to 22.5dB, 1.5dB steps.
// - gain register lower nibble sets sidetone attenuation -12.5 to -27.5dB, 1dB steps.
// - receive gain upper nibble sets earpiece gain 0 to -30dB, 2dB steps.
// - receive gain lower nibble sets extra amplifier gain downward, 2dB steps.
// - tone register upper nibble attenuates generator output down to -27dB.
// - generator select bits pick tone one, tone two, summed or mute.
// - waveform bit selects sinewave or squarewave generator output.
// - tone injection bit routes generator into transmit data path.
// - tone frequency equals register value over 0.128, 0.256 or 0.064.
// - two range bits select standard, halved or doubled frequency range.
// - range code 00 standard default, 01 halved, 10 doubled, 11 forbidden.
package ctg_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;
	// register indices in the address field of the command byte
	localparam logic [3:0] REG_IFC = 4'h1;
	localparam logic [3:0] REG_RXD = 4'h2;
	localparam logic [3:0] REG_TXD = 4'h3;
	localparam logic [3:0] REG_PATH = 4'h4;
	localparam logic [3:0] REG_TXG = 4'h5;
	localparam logic [3:0] REG_RXG = 4'h6;
	localparam logic [3:0] REG_TONE = 4'h7;
	localparam logic [3:0] REG_F1 = 4'h8;
	localparam logic [3:0] REG_F2 = 4'h9;
	localparam logic [3:0] REG_RANGE = 4'ha;
	// command byte fields
	localparam int CMD_READ_BIT = 7;
	// interface control bits
	localparam int IFC_RXOVR = 4;
	localparam int IFC_TXOVR = 3;
	localparam int IFC_VOICE = 2;
	localparam int IFC_SLOT = 1;
	localparam int IFC_SUPPLY = 0;
	// path select bits
	localparam int PATH_SIDE = 5;
	localparam int PATH_OE1 = 4;
	localparam int PATH_OE2 = 3;
	localparam int PATH_TONE = 2;
	localparam int PATH_SPEECH = 0;
	localparam logic [1:0] MIC_MUTE = 2'h3;
	// tone control bits
	localparam int TONE_F1 = 3;
	localparam int TONE_F2 = 2;
	localparam int TONE_WAVE = 1;
	localparam int TONE_INJ = 0;
	// range codes
	localparam logic [1:0] RANGE_STD = 2'h0;
	localparam logic [1:0] RANGE_HALF = 2'h1;
	localparam logic [1:0] RANGE_DBL = 2'h2;
	// reset values
	localparam logic [7:0] RST_REG = 8'h00;
	// tone base tick: 1.024 MHz, phase of 18 bits gives 3.90625 Hz per step
	localparam longint CLK_HZ = 100000000;
	localparam longint TICK_HZ = 1024000;
	localparam int NCO_W = 32;
	localparam logic [31:0] TICK_INC = 32'((TICK_HZ * (64'd1 << NCO_W)) / CLK_HZ);
	localparam int PH_W = 18;
	// summed mode scale for tone two, about -2 dB (203/256)
	localparam logic [7:0] F2_SCALE = 8'hcb;
	// decoded pins after synchronising
	typedef struct packed {
		logic cclk;
		logic cs_b;
		logic cdi;
		logic bclk;
		logic fs;
		logic dr;
	} ctg_pins_t;
	// analog front end settings
	typedef struct packed {
		logic [1:0] mic_sel;
		logic sidetone_en;
		logic earpiece_en;
		logic extra_en;
		logic tone_to_earpiece;
		logic speech_to_earpiece;
		logic [3:0] tx_gain;
		logic [3:0] sidetone_att;
		logic [3:0] ear_gain;
		logic [3:0] extra_gain;
		logic [3:0] tone_att;
		logic tone_inject;
		logic supply_sel;
	} ctg_analog_t;
endpackage

//--- ctg_top.sv
// codec control register bank, PCM slot port and ring/tone generator
`timescale 1ns/1ps
`default_nettype none
module ctg_top #(
	parameter int DW = 8
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic cclk_i,
	input wire logic cs_b_i,
	input wire logic cdi_i,
	output logic cdo_o,
	output logic cdo_oe_b_o,
	input wire logic bclk_i,
	input wire logic fs_i,
	input wire logic dr_i,
	output logic dx_o,
	output logic dx_oe_b_o,
	input wire logic [DW-1:0] enc_data_i,
	input wire logic enc_valid_i,
	output logic enc_ready_o,
	output logic [DW-1:0] dec_data_o,
	output logic dec_valid_o,
	input wire logic dec_ready_i,
	output ctg_pkg::ctg_analog_t analog_o,
	output logic [7:0] tone_sample_o
);
	import ctg_pkg::*;

	logic [7:0] regs_q [0:10];
	ctg_pins_t s1_q, s2_q, s3_q, st_q, prev_q;
	logic [15:0] csh_q;
	logic [4:0] cbits_q;
	logic [7:0] cout_q;
	logic rd_q;
	logic [3:0] fbits_q;
	logic [7:0] rsh_q, tsh_q;
	logic in_frame_q, slot_act_q;
	logic [7:0] rxd_q;
	logic push_pend_q;
	logic [7:0] push_byte_q;
	logic [DW-1:0] buf_q [0:1];
	logic [1:0] cnt_q;
	logic rd_ptr_q, wr_ptr_q;
	logic [31:0] nco_q;
	logic [PH_W-1:0] ph1_q, ph2_q;
	logic [7:0] smp_q;

	logic cclk_rise, cclk_fall, cs_rise, cs_fall, bclk_rise, bclk_fall, fs_rise;
	logic voice_en, slot_first, slot_last, buf_in_ready, buf_push, buf_pop, tick;
	logic [PH_W-1:0] ph_add1, ph_add2;
	logic [7:0] w1, w2;
	logic [8:0] sum;
	logic [3:0] cmd_addr;

	// three-stage synchronisers, a change counts when stages two and three agree
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			// all stages start at the idle pin levels, select high, so no false edge follows reset
			s1_q <= 6'h10;
			s2_q <= 6'h10;
			s3_q <= 6'h10;
			st_q <= 6'h10;
			prev_q <= 6'h10;
		end else if (ce_i) begin
			s1_q <= {cclk_i, cs_b_i, cdi_i, bclk_i, fs_i, dr_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < 6; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					st_q[i] <= s3_q[i];
				end
			end
			prev_q <= st_q;
		end
	end

	assign cclk_rise = st_q.cclk & ~prev_q.cclk;
	assign cclk_fall = ~st_q.cclk & prev_q.cclk;
	assign cs_fall = ~st_q.cs_b & prev_q.cs_b;
	assign cs_rise = st_q.cs_b & ~prev_q.cs_b;
	assign bclk_rise = st_q.bclk & ~prev_q.bclk;
	assign bclk_fall = ~st_q.bclk & prev_q.bclk;
	assign fs_rise = st_q.fs & ~prev_q.fs;

	// command address completes with the eighth bit, still on the synced data pin
	assign cmd_addr = {csh_q[ADDR_W-2:0], st_q.cdi};

	// serial control port: command byte then data byte, msb first
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			csh_q <= '0;
			cbits_q <= '0;
			rd_q <= 1'b0;
			cout_q <= '0;
		end else if (ce_i) begin
			if (cs_fall) begin
				cbits_q <= '0;
				rd_q <= 1'b0;
			end else if (!st_q.cs_b && cclk_rise && cbits_q != 5'h10) begin
				csh_q <= {csh_q[14:0], st_q.cdi};
				cbits_q <= cbits_q + 5'h1;
				if (cbits_q == 5'h7) begin
					rd_q <= csh_q[CMD_READ_BIT - 1];
					case (cmd_addr)
						REG_RXD: cout_q <= rxd_q;
						REG_TXD: cout_q <= '0;
						default: begin
							// unmapped addresses read zero
							if (cmd_addr >= REG_IFC && cmd_addr <= REG_RANGE) begin
								cout_q <= regs_q[cmd_addr];
							end else begin
								cout_q <= '0;
							end
						end
					endcase
				end
			end else if (!st_q.cs_b && cclk_fall && rd_q && cbits_q > 5'h8) begin
				// msb stands through the ninth rise, later bits follow each fall
				cout_q <= {cout_q[6:0], 1'b0};
			end else if (cs_rise) begin
				// drop the read flag so the next select does not drive cdo early
				rd_q <= 1'b0;
			end
		end
	end

	// read data driven while selected in the data byte of a read
	assign cdo_o = cout_q[7];
	assign cdo_oe_b_o = ~(rd_q & ~st_q.cs_b & cbits_q >= 5'h8);

	// register writes at the close of a full write, received byte capture
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < 11; i++) begin
				regs_q[i] <= RST_REG;
			end
			rxd_q <= RST_REG;
		end else if (ce_i) begin
			if (cs_rise && cbits_q == 5'h10 && !csh_q[8 + CMD_READ_BIT]) begin
				if (csh_q[11:8] == REG_RXD) begin
					// host byte for the receive path
					rxd_q <= csh_q[7:0];
				end else if (csh_q[11:8] >= REG_IFC && csh_q[11:8] <= REG_RANGE) begin
					regs_q[csh_q[11:8]] <= csh_q[7:0];
				end
			end else if (slot_last && bclk_fall && !regs_q[REG_IFC][IFC_RXOVR]) begin
				rxd_q <= {rsh_q[6:0], st_q.dr};
			end
		end
	end

	assign voice_en = regs_q[REG_IFC][IFC_VOICE];

	// PCM frame bit counter; slot offset of 0 or 8 bits
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fbits_q <= '0;
			in_frame_q <= 1'b0;
			slot_act_q <= 1'b0;
		end else if (ce_i) begin
			if (fs_rise) begin
				fbits_q <= '0;
				in_frame_q <= 1'b1;
				slot_act_q <= 1'b0;
			end else if (in_frame_q && bclk_rise) begin
				slot_act_q <= voice_en && (fbits_q[3] == regs_q[REG_IFC][IFC_SLOT]);
				fbits_q <= fbits_q + 4'h1;
				if (fbits_q == 4'hf) begin
					in_frame_q <= 1'b0;
				end
			end else if (!in_frame_q && bclk_fall) begin
				// last fall of the frame closes a second-slot transfer, dx floats again
				slot_act_q <= 1'b0;
			end
		end
	end

	assign slot_first = in_frame_q && bclk_rise && voice_en && fbits_q == {regs_q[REG_IFC][IFC_SLOT], 3'h0};
	assign slot_last = slot_act_q && fbits_q[2:0] == 3'h0 && fbits_q != 4'h0 ? 1'b1 :
		slot_act_q && fbits_q == 4'h0 && !in_frame_q;

	// msb first shift registers for both directions
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rsh_q <= '0;
			tsh_q <= '0;
		end else if (ce_i) begin
			if (slot_first) begin
				if (regs_q[REG_IFC][IFC_TXOVR])
					tsh_q <= regs_q[REG_TXD];
				else if (enc_valid_i)
					tsh_q <= enc_data_i;
				else
					tsh_q <= '0;
			end else if (slot_act_q && bclk_rise) begin
				tsh_q <= {tsh_q[6:0], 1'b0};
			end
			if (slot_act_q && bclk_fall) begin
				rsh_q <= {rsh_q[6:0], st_q.dr};
			end
		end
	end

	// encoder sample taken only when not overridden
	assign enc_ready_o = slot_first & ce_i & ~regs_q[REG_IFC][IFC_TXOVR];
	assign dx_o = tsh_q[7];
	assign dx_oe_b_o = ~slot_act_q;

	// byte to decode, held until the buffer accepts it
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			push_pend_q <= 1'b0;
			push_byte_q <= '0;
		end else if (ce_i) begin
			if (slot_last && bclk_fall) begin
				push_pend_q <= 1'b1;
				push_byte_q <= regs_q[REG_IFC][IFC_RXOVR] ? rxd_q : {rsh_q[6:0], st_q.dr};
			end else if (buf_push) begin
				push_pend_q <= 1'b0;
			end
		end
	end

	// two-entry buffer in front of the decoder
	assign buf_in_ready = cnt_q != 2'h2;
	assign buf_push = push_pend_q & buf_in_ready;
	assign buf_pop = dec_ready_i & (cnt_q != 2'h0);
	assign dec_valid_o = cnt_q != 2'h0;
	assign dec_data_o = buf_q[rd_ptr_q];

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			buf_q[0] <= '0;
			buf_q[1] <= '0;
			cnt_q <= '0;
			rd_ptr_q <= 1'b0;
			wr_ptr_q <= 1'b0;
		end else if (ce_i) begin
			if (buf_push) begin
				buf_q[wr_ptr_q] <= push_byte_q[DW-1:0];
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (buf_pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			cnt_q <= cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
		end
	end

	// base tick of the tone oscillators
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			nco_q <= '0;
		end else if (ce_i) begin
			nco_q <= nco_q + TICK_INC;
		end
	end

	// wrap of the base accumulator marks one tick, frozen with the clock enable
	assign tick = ce_i & (nco_q > (nco_q + TICK_INC));

	// range scales the phase step; forbidden code treated as standard
	always_comb begin
		case (regs_q[REG_RANGE][1:0])
			RANGE_HALF: begin
				ph_add1 = PH_W'(regs_q[REG_F1]);
				ph_add2 = PH_W'(regs_q[REG_F2]);
			end
			RANGE_DBL: begin
				ph_add1 = PH_W'({regs_q[REG_F1], 2'h0});
				ph_add2 = PH_W'({regs_q[REG_F2], 2'h0});
			end
			default: begin
				ph_add1 = PH_W'({regs_q[REG_F1], 1'b0});
				ph_add2 = PH_W'({regs_q[REG_F2], 1'b0});
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ph1_q <= '0;
			ph2_q <= '0;
		end else if (tick) begin
			ph1_q <= ph1_q + ph_add1;
			ph2_q <= ph2_q + ph_add2;
		end
	end

	// quarter-wave sine lookup, offset binary around 8'h80
	function automatic logic [7:0] wave(input logic [PH_W-1:0] ph, input logic square);
		logic [2:0] idx;
		logic [6:0] mag;
		idx = ph[PH_W-2] ? ~ph[PH_W-3:PH_W-5] : ph[PH_W-3:PH_W-5];
		case (idx)
			3'h0: mag = 7'h0c;
			3'h1: mag = 7'h25;
			3'h2: mag = 7'h3c;
			3'h3: mag = 7'h50;
			3'h4: mag = 7'h61;
			3'h5: mag = 7'h6e;
			3'h6: mag = 7'h78;
			default: mag = 7'h7d;
		endcase
		if (square)
			mag = 7'h7f;
		wave = ph[PH_W-1] ? 8'h80 - {1'b0, mag} : 8'h80 + {1'b0, mag};
	endfunction

	// waveform choice; tone selection and summing
	always_comb begin
		w1 = wave(ph1_q, ~regs_q[REG_TONE][TONE_WAVE]);
		w2 = wave(ph2_q, ~regs_q[REG_TONE][TONE_WAVE]);
		sum = 9'({1'b0, w1[7:1]}) + 9'((16'(w2) * 16'(F2_SCALE)) >> 9);
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			smp_q <= 8'h80;
		end else if (ce_i) begin
			// one sample a cycle; mute parks the output at mid-scale
			case (regs_q[REG_TONE][TONE_F1:TONE_F2])
				2'h1: smp_q <= w2;
				2'h2: smp_q <= w1;
				2'h3: smp_q <= sum[7:0] + 8'h40 - 8'h40;
				default: smp_q <= 8'h80;
			endcase
		end
	end

	assign tone_sample_o = smp_q;

	// analog front end settings from the registers
	always_comb begin
		analog_o.mic_sel = regs_q[REG_PATH][7:6];
		// sidetone forced off with transmit path disabled
		analog_o.sidetone_en = regs_q[REG_PATH][PATH_SIDE] & voice_en & (regs_q[REG_PATH][7:6] != MIC_MUTE);
		// output enables, both set treated as mute
		analog_o.earpiece_en = regs_q[REG_PATH][PATH_OE1] & ~regs_q[REG_PATH][PATH_OE2];
		analog_o.extra_en = regs_q[REG_PATH][PATH_OE2] & ~regs_q[REG_PATH][PATH_OE1];
		analog_o.tone_to_earpiece = regs_q[REG_PATH][PATH_TONE];
		analog_o.speech_to_earpiece = regs_q[REG_PATH][PATH_SPEECH];
		analog_o.tx_gain = regs_q[REG_TXG][7:4];
		analog_o.sidetone_att = regs_q[REG_TXG][3:0];
		analog_o.ear_gain = regs_q[REG_RXG][7:4];
		analog_o.extra_gain = regs_q[REG_RXG][3:0];
		analog_o.tone_att = regs_q[REG_TONE][7:4];
		analog_o.tone_inject = regs_q[REG_TONE][TONE_INJ];
		analog_o.supply_sel = regs_q[REG_IFC][IFC_SUPPLY];
	end
endmodule
`default_nettype wire

//--- ctg_assertions.sv
// port checker for the codec control bank, bound into the top
`timescale 1ns/1ps
`default_nettype none
module ctg_assertions
	import ctg_pkg::*;
#(
	parameter int DW = 8
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic cs_b_i,
	input wire logic cdo_oe_b_o,
	input wire logic bclk_i,
	input wire logic dx_o,
	input wire logic dx_oe_b_o,
	input wire logic enc_ready_o,
	input wire logic [DW-1:0] dec_data_o,
	input wire logic dec_valid_o,
	input wire logic dec_ready_i,
	input wire ctg_pkg::ctg_analog_t analog_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// idle spans of the control select and the bit clock
	sequence ctl_idle_s;
		cs_b_i [*8];
	endsequence
	sequence bclk_still_s;
		!bclk_i [*8];
	endsequence
	ready_drive_a: assert property (
		enc_ready_o |-> ##[0:2] !dx_oe_b_o) else $error("slot start without drive");
	ready_pulse_a: assert property (
		enc_ready_o |=> !enc_ready_o) else $error("slot pulse too long");
	dx_hold_a: assert property (
		bclk_still_s |-> $stable(dx_o)) else $error("dx moved without bit clock");
	dec_hold_a: assert property (
		dec_valid_o && !dec_ready_i |=> dec_valid_o && $stable(dec_data_o)) else $error("stalled byte lost");
	cdo_release_a: assert property (
		ctl_idle_s |-> cdo_oe_b_o) else $error("cdo driven while deselected");
	regs_quiet_a: assert property (
		ctl_idle_s |-> $stable(analog_o)) else $error("settings moved while idle");
	out_excl_a: assert property (
		!(analog_o.earpiece_en && analog_o.extra_en)) else $error("both outputs enabled");
	side_off_a: assert property (
		analog_o.mic_sel == MIC_MUTE |-> !analog_o.sidetone_en) else $error("sidetone on while muted");
endmodule
bind ctg_top ctg_assertions #(.DW(DW)) i_ctg_assertions (.*);
`default_nettype wire

//--- ctg_pcm_far.sv
// far side PCM port model: bit clock, frame sync, receive data, capture of dx
`timescale 1ns/1ps
`default_nettype none
module ctg_pcm_far (
	input wire logic clk_i,
	input wire logic dx_i,
	input wire logic dx_oe_b_i,
	output logic bclk_o,
	output logic fs_o,
	output logic dr_o
);
	localparam int HALF = 6;
	initial begin
		bclk_o = 1'b0;
		fs_o = 1'b0;
		dr_o = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// one frame of two slots; bit clock stands low outside the frame
	task automatic frame(input logic [15:0] rx, output logic [15:0] tx, output logic [15:0] drv);
		fs_o = 1'b1;
		wt(HALF);
		for (int b = 0; b < 16; b++) begin
			bclk_o = 1'b1;
			dr_o = rx[15-b];
			wt(HALF);
			tx[15-b] = dx_i;
			drv[15-b] = !dx_oe_b_i;
			bclk_o = 1'b0;
			fs_o = 1'b0;
			wt(HALF);
		end
		dr_o = ~dr_o; // receive data inverted after the last bit
	endtask
endmodule
`default_nettype wire

//--- ctg_top_bench.sv
// self-checking bench for the codec control bank and PCM slot port
`timescale 1ns/1ps
`default_nettype none
module ctg_top_bench;
	import ctg_pkg::*;
	logic clk_i, rst_b_i, ce_i, cclk_i, cs_b_i, cdi_i, cdo_o, cdo_oe_b_o;
	logic bclk_i, fs_i, dr_i, dx_o, dx_oe_b_o, enc_valid_i, enc_ready_o, dec_valid_o, dec_ready_i;
	logic [7:0] enc_data_i, dec_data_o, tone_sample_o, q, d;
	logic [15:0] seed, tx, drv;
	logic [7:0] val [6];
	logic [3:0] regs [6] = '{REG_PATH, REG_TXG, REG_RXG, REG_TONE, REG_F1, REG_F2};
	logic [7:0] dec_q [$];
	ctg_analog_t analog_o;
	int mismatches = 0;
	int total_checks = 0;
	ctg_top i_ctg_top (.*);
	ctg_pcm_far i_ctg_pcm_far (.clk_i(clk_i), .dx_i(dx_o), .dx_oe_b_i(dx_oe_b_o), .bclk_o(bclk_i),
		.fs_o(fs_i), .dr_o(dr_i));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// one 16-bit control frame, read byte collected from cdo
	task automatic ctl(input logic rd, input logic [3:0] a, input logic [7:0] dv, output logic [7:0] r);
		logic [15:0] w;
		w = {rd, 3'h0, a, dv};
		r = 8'h00;
		cs_b_i = 1'b0;
		wt(8);
		for (int b = 0; b < 16; b++) begin
			cdi_i = w[15-b];
			wt(8);
			cclk_i = 1'b1;
			wt(8);
			if (b > 7) r[15-b] = cdo_o;
			cclk_i = 1'b0;
		end
		wt(8);
		cs_b_i = 1'b1;
		wt(8);
	endtask
	// decoded stream compared against noted bytes
	always @(posedge clk_i) begin
		if (rst_b_i === 1'b1 && dec_valid_o === 1'b1 && dec_ready_i === 1'b1) begin
			if (dec_q.size() == 0) begin
				chk("unexpected byte", 16'h0, 16'h1);
			end else begin
				chk("decoded byte", dec_q.pop_front(), dec_data_o);
			end
		end
	end
	// hang guard
	initial begin
		wt(60000);
		mismatches++;
		print_verdict();
	end
	initial begin
		{rst_b_i, cclk_i, cdi_i, enc_valid_i, dec_ready_i, enc_data_i} = '0;
		{ce_i, cs_b_i} = 2'b11;
		seed = 16'd54676;
		wt(12);
		rst_b_i = 1'b1;
		wt(8);
		chk("analog reset", 16'h1, analog_o === '0);
		for (int r = 1; r <= 10; r++) begin
			ctl(1'b1, 4'(r), 8'h00, q);
			chk("reset value", 8'h00, q);
		end
		// random settings, outputs never both on
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			d = seed[7:0];
			if (i == 0) d[4:3] = {d[4], !d[4]};
			val[i] = d;
			ctl(1'b0, regs[i], d, q);
			ctl(1'b1, regs[i], 8'h00, q);
			chk("readback", d, q);
		end
		chk("mic select", val[0][7:6], analog_o.mic_sel);
		chk("sidetone gated", 16'h0, analog_o.sidetone_en);
		chk("earpiece", val[0][4], analog_o.earpiece_en);
		chk("extra out", val[0][3], analog_o.extra_en);
		chk("tone route", val[0][2], analog_o.tone_to_earpiece);
		chk("speech route", val[0][0], analog_o.speech_to_earpiece);
		chk("tx gain", val[1][7:4], analog_o.tx_gain);
		chk("side att", val[1][3:0], analog_o.sidetone_att);
		chk("ear gain", val[2][7:4], analog_o.ear_gain);
		chk("extra gain", val[2][3:0], analog_o.extra_gain);
		chk("tone att", val[3][7:4], analog_o.tone_att);
		chk("injection", val[3][0], analog_o.tone_inject);
		for (int c = 1; c < 3; c++) begin
			ctl(1'b0, REG_RANGE, 8'(c), q);
			ctl(1'b1, REG_RANGE, 8'h00, q);
			chk("range", 8'(c), q);
		end
		ctl(1'b0, REG_IFC, 8'h01, q);
		chk("supply", 16'h1, analog_o.supply_sel);
		// single tones as square and sine, then muted
		ctl(1'b0, REG_TONE, 8'h08, q);
		chk("square f1", 16'h1, 16'(tone_sample_o == 8'hff || tone_sample_o == 8'h01));
		ctl(1'b0, REG_TONE, 8'h04, q);
		chk("square f2", 16'h1, 16'(tone_sample_o == 8'hff || tone_sample_o == 8'h01));
		ctl(1'b0, REG_TONE, 8'h0a, q);
		chk("sine f1", 16'h1, 16'(tone_sample_o != 8'hff && tone_sample_o != 8'h01 && tone_sample_o != 8'h80));
		ctl(1'b0, REG_TONE, 8'h00, q);
		chk("tones muted", 16'h80, tone_sample_o);
		ctl(1'b0, REG_TXD, 8'h96, q);
		ctl(1'b1, REG_TXD, 8'h00, q);
		chk("tx reg read", 8'h00, q);
		ctl(1'b0, 4'hb, 8'h5a, q);
		ctl(1'b1, 4'hb, 8'h00, q);
		chk("unmapped", 8'h00, q);
		dec_ready_i = 1'b1;
		ctl(1'b0, REG_IFC, 8'h0c, q);
		dec_q.push_back(8'h5a);
		i_ctg_pcm_far.frame(16'h5ac3, tx, drv);
		chk("slot drive", 16'hff00, drv);
		chk("override byte", 8'h96, tx[15:8]);
		seed = lfsr(seed);
		enc_data_i = seed[7:0];
		enc_valid_i = 1'b1;
		ctl(1'b0, REG_IFC, 8'h06, q);
		dec_q.push_back(8'he1);
		i_ctg_pcm_far.frame(16'h3ce1, tx, drv);
		chk("slot two drive", 16'h00ff, drv);
		chk("encoder byte", seed[7:0], tx[7:0]);
		ctl(1'b1, REG_RXD, 8'h00, q);
		chk("received byte", 8'he1, q);
		ctl(1'b0, REG_PATH, 8'h20, q);
		chk("sidetone on", 16'h1, analog_o.sidetone_en);
		ctl(1'b0, REG_PATH, 8'he0, q);
		chk("sidetone muted", 16'h0, analog_o.sidetone_en);
		// clock enable low: a control frame meets frozen pins and is lost
		ce_i = 1'b0;
		ctl(1'b0, REG_PATH, 8'h08, q);
		ce_i = 1'b1;
		ctl(1'b1, REG_PATH, 8'h00, q);
		chk("frozen write", 8'he0, q);
		// host byte decoded instead of pin
		ctl(1'b0, REG_IFC, 8'h14, q);
		ctl(1'b0, REG_RXD, 8'h77, q);
		dec_q.push_back(8'h77);
		i_ctg_pcm_far.frame(16'h1234, tx, drv);
		// voice off: no drive, no decode
		ctl(1'b0, REG_IFC, 8'h00, q);
		i_ctg_pcm_far.frame(16'h4321, tx, drv);
		chk("voice off drive", 16'h0000, drv);
		// buffer filled while the receiver stalls, then drained
		ctl(1'b0, REG_IFC, 8'h04, q);
		dec_ready_i = 1'b0;
		dec_q.push_back(8'ha1);
		i_ctg_pcm_far.frame(16'ha100, tx, drv);
		dec_q.push_back(8'hb2);
		i_ctg_pcm_far.frame(16'hb200, tx, drv);
		chk("stalled valid", 16'h1, dec_valid_o);
		dec_ready_i = 1'b1;
		wt(20);
		chk("all decoded", 16'h0, 16'(dec_q.size()));
		print_verdict();
	end
endmodule
`default_nettype wire
